/* File: common/mbrd_consts.vh */
// constants for the read-inputs / read-holding-registers request handler
// assumes plain verilog-2005 inclusion by bare name
`ifndef MBRD_CONSTS_VH
`define MBRD_CONSTS_VH
`define MBRD_FC_READ_INPUTS   8'h02
`define MBRD_FC_READ_HOLDING  8'h03
`define MBRD_EXC_FLAG         8'h80
`define MBRD_EXC_ILLEGAL_FUNC 8'h01
`define MBRD_EXC_ILLEGAL_ADDR 8'h02
`define MBRD_DI_ADDR_MAX      16'h000F
`define MBRD_DI_QTY_MIN       16'h0001
`define MBRD_DI_QTY_MAX       16'h0010
`define MBRD_HR_ADDR_MAX_FLT  16'h000E
`define MBRD_HR_ADDR_MAX_CNT  16'h000F
`define MBRD_HR_QTY_MAX_FLT   16'h0008
`define MBRD_HR_QTY_MAX_CNT   16'h0010
`define MBRD_REQ_LEN          3'h5
`define MBRD_RSP_MAX          6'h22
`endif

/* File: src/mbrd_slave.v */
// request handler for modbus read discrete inputs (02) and read holding regs (03)
// assumes: request pdu bytes (unit id already stripped) arrive one per strobe,
// response bytes leave one per rsp_ready handshake; bus and settings share clk_i,
// while the digital inputs come straight from pins and are synchronised here.
`include "mbrd_consts.vh"
module mbrd_slave #(
  parameter NUM_CH = 16
) (
  input  wire         clk_i,
  input  wire         rstn_i,
  input  wire [15:0]  digital_in_active_i,
  input  wire [255:0] analog_in_words_i,
  input  wire [255:0] analog_out_words_i,
  input  wire         analog_value_format_select_i,
  input  wire         holding_input_swap_select_i,
  input  wire         req_valid_i,
  input  wire [7:0]   req_byte_i,
  input  wire         req_last_i,
  output wire         req_ready_o,
  output wire         rsp_valid_o,
  output reg  [7:0]   rsp_byte_o,
  output wire         rsp_last_o,
  input  wire         rsp_ready_i,
  input  wire         mst_rsp_valid_i,
  input  wire [7:0]   mst_rsp_func_i,
  input  wire [7:0]   mst_rsp_exc_i,
  output reg  [7:0]   last_response_function_query_o,
  output reg  [7:0]   last_exception_code_query_o
);

// ----------------------------------------
// state encoding
// ----------------------------------------
localparam ST_RECV = 2'h0;
localparam ST_EVAL = 2'h1;
localparam ST_SEND = 2'h2;
localparam ST_DROP = 2'h3;

reg [1:0]  state_reg;
reg [1:0]  state_next;
reg [7:0]  func_reg;
reg [15:0] addr_reg;
reg [15:0] qty_reg;
reg [2:0]  cnt_reg;
reg [5:0]  idx_reg;
reg [5:0]  len_reg;
reg [7:0]  buf_reg [0:`MBRD_RSP_MAX - 1];
reg        exc_reg;

// ----------------------------------------
// helpers
// ----------------------------------------
// byte k (0 = msb) of a 16-bit word taken from a 16-word bus
function [7:0] word_byte;
  input [255:0] bus;
  input [4:0]   widx;
  input         lo;
  begin
    word_byte = bus[{widx[3:0], ~lo, 3'h0} +: 8];
  end
endfunction

// true when the run from start reaches past the first limit channels; worked in
// 17 bits so a quantity near 0xFFFF cannot wrap back into range
function span_over;
  input [15:0] start;
  input [15:0] count;
  input [15:0] limit;
  begin
    span_over = ({1'b0, start} + {1'b0, count}) > {1'b0, limit};
  end
endfunction

assign req_ready_o = (state_reg == ST_RECV) || (state_reg == ST_DROP);
assign rsp_valid_o = (state_reg == ST_SEND);
assign rsp_last_o  = rsp_valid_o && (idx_reg == len_reg - 6'h01);

// ----------------------------------------
// digital input synchroniser
// ----------------------------------------
// pins are asynchronous to clk_i: three stages, and a level only counts
// once stages two and three agree, so a one-cycle glitch never reaches
// a status byte; costs four cycles of latency on an input change
reg [15:0] din_meta_reg;
reg [15:0] din_sync_reg;
reg [15:0] din_hold_reg;
reg [15:0] din_clean_reg;
reg [15:0] din_clean_next;
integer    b;

always @* begin
  din_clean_next = din_clean_reg;
  for (b = 0; b < NUM_CH; b = b + 1) begin
    if (din_sync_reg[b] == din_hold_reg[b])
      din_clean_next[b] = din_sync_reg[b];
  end
end

always @(posedge clk_i or negedge rstn_i) begin
  if (!rstn_i) begin
    din_meta_reg  <= 16'h0000;
    din_sync_reg  <= 16'h0000;
    din_hold_reg  <= 16'h0000;
    din_clean_reg <= 16'h0000;
  end else begin
    din_meta_reg  <= digital_in_active_i;
    din_sync_reg  <= din_meta_reg;
    din_hold_reg  <= din_sync_reg;
    din_clean_reg <= din_clean_next;
  end
end

// ----------------------------------------
// request evaluation
// ----------------------------------------
reg        bad_func;
reg        bad_addr;
reg [15:0] di_bits;
// six bits: sixteen count registers give a byte count of 0x20
reg [5:0]  nbytes;
reg [15:0] di_shift;
reg [255:0] src_bus;
integer    i;

always @* begin
  bad_func = 1'b0;
  bad_addr = 1'b0;
  nbytes   = 6'h00;
  di_bits  = 16'h0000;
  // inverted input sense
  // active reads zero
  di_shift = (~din_clean_reg) >> addr_reg[3:0];
  src_bus  = holding_input_swap_select_i ? analog_out_words_i : analog_in_words_i;
  if (func_reg == `MBRD_FC_READ_INPUTS) begin
    bad_addr = (addr_reg > `MBRD_DI_ADDR_MAX) || (qty_reg < `MBRD_DI_QTY_MIN) ||
               (qty_reg > `MBRD_DI_QTY_MAX) ||
               span_over(addr_reg, qty_reg, `MBRD_DI_QTY_MAX);
    for (i = 0; i < NUM_CH; i = i + 1)
      di_bits[i] = (i < qty_reg) ? di_shift[i] : 1'b0;
    nbytes = {1'b0, qty_reg[4:0] + 5'h07} >> 3;
  end else if (func_reg == `MBRD_FC_READ_HOLDING) begin
    if (analog_value_format_select_i) begin
      bad_addr = (addr_reg > `MBRD_HR_ADDR_MAX_CNT) || (qty_reg == 16'h0000) ||
                 (qty_reg > `MBRD_HR_QTY_MAX_CNT) ||
                 span_over(addr_reg, qty_reg, `MBRD_HR_QTY_MAX_CNT);
    end else begin
      bad_addr = (addr_reg > `MBRD_HR_ADDR_MAX_FLT) || (qty_reg == 16'h0000) ||
                 (qty_reg > `MBRD_HR_QTY_MAX_FLT) || addr_reg[0] || qty_reg[0] ||
                 span_over(addr_reg, qty_reg, `MBRD_HR_QTY_MAX_CNT);
    end
    nbytes = {qty_reg[4:0], 1'b0};
  end else begin
    bad_func = 1'b1;
  end
end

// ----------------------------------------
// sequencer
// ----------------------------------------
always @* begin
  state_next = state_reg;
  case (state_reg)
    ST_RECV: begin
      if (req_valid_i && req_last_i)
        state_next = ST_EVAL;
      else if (req_valid_i && cnt_reg == `MBRD_REQ_LEN - 3'h1)
        state_next = ST_DROP;
    end
    ST_DROP: begin
      if (req_valid_i && req_last_i)
        state_next = ST_EVAL;
    end
    ST_EVAL: state_next = ST_SEND;
    ST_SEND: begin
      if (rsp_ready_i && rsp_last_o)
        state_next = ST_RECV;
    end
    default: state_next = ST_RECV;
  endcase
end

integer k;
always @(posedge clk_i or negedge rstn_i) begin
  if (!rstn_i) begin
    state_reg <= ST_RECV;
    func_reg  <= 8'h00;
    addr_reg  <= 16'h0000;
    qty_reg   <= 16'h0000;
    cnt_reg   <= 3'h0;
    idx_reg   <= 6'h00;
    len_reg   <= 6'h01;
    exc_reg   <= 1'b0;
    rsp_byte_o <= 8'h00;
    for (k = 0; k < `MBRD_RSP_MAX; k = k + 1)
      buf_reg[k] <= 8'h00;
  end else begin
    state_reg <= state_next;
    case (state_reg)
      ST_RECV: begin
        if (req_valid_i) begin
          // pdu only, unit id never seen
          case (cnt_reg)
            3'h0: func_reg <= req_byte_i;
            3'h1: addr_reg[15:8] <= req_byte_i;
            3'h2: addr_reg[7:0]  <= req_byte_i;
            3'h3: qty_reg[15:8]  <= req_byte_i;
            default: qty_reg[7:0] <= req_byte_i;
          endcase
          cnt_reg <= req_last_i ? 3'h0 : cnt_reg + 3'h1;
          // short frame for known function reads as bad address
          if (req_last_i && cnt_reg < `MBRD_REQ_LEN - 3'h1) begin
            qty_reg <= 16'h0000;
            if (cnt_reg == 3'h0)
              func_reg <= req_byte_i;
          end
        end
      end
      ST_DROP: cnt_reg <= 3'h0;
      ST_EVAL: begin
        idx_reg <= 6'h00;
        if (bad_func || bad_addr) begin
          buf_reg[0] <= func_reg | `MBRD_EXC_FLAG;
          buf_reg[1] <= bad_func ? `MBRD_EXC_ILLEGAL_FUNC : `MBRD_EXC_ILLEGAL_ADDR;
          len_reg <= 6'h02;
          exc_reg <= 1'b1;
        end else begin
          buf_reg[0] <= func_reg;
          buf_reg[1] <= {2'h0, nbytes};
          len_reg <= nbytes + 6'h02;
          exc_reg <= 1'b0;
          if (func_reg == `MBRD_FC_READ_INPUTS) begin
            buf_reg[2] <= di_bits[7:0];
            buf_reg[3] <= di_bits[15:8];
          end else begin
            for (k = 0; k < 16; k = k + 1) begin
              buf_reg[2 + 2 * k] <= word_byte(src_bus, addr_reg[4:0] + k[4:0], 1'b0);
              buf_reg[3 + 2 * k] <= word_byte(src_bus, addr_reg[4:0] + k[4:0], 1'b1);
            end
          end
        end
        rsp_byte_o <= (bad_func || bad_addr) ? (func_reg | `MBRD_EXC_FLAG) : func_reg;
      end
      ST_SEND: begin
        if (rsp_ready_i && !rsp_last_o) begin
          idx_reg    <= idx_reg + 6'h01;
          rsp_byte_o <= buf_reg[idx_reg + 6'h01];
        end
      end
      default: cnt_reg <= 3'h0;
    endcase
  end
end

// ----------------------------------------
// master-side response status
// ----------------------------------------
always @(posedge clk_i or negedge rstn_i) begin
  if (!rstn_i) begin
    last_response_function_query_o <= 8'h00;
    last_exception_code_query_o    <= 8'h00;
  end else if (mst_rsp_valid_i) begin
    last_response_function_query_o <= mst_rsp_func_i;
    if (mst_rsp_func_i[7])
      last_exception_code_query_o <= mst_rsp_exc_i;
  end
end

endmodule

/* File: tb/mbrd_slave_asserts.sv */
// checker on the request handler ports
// assumes one clock and an async active-low reset
module mbrd_slave_asserts (
  input wire       clk_i,
  input wire       rstn_i,
  input wire       req_valid_i,
  input wire       req_last_i,
  input wire       req_ready_o,
  input wire       rsp_valid_o,
  input wire [7:0] rsp_byte_o,
  input wire       rsp_last_o,
  input wire       rsp_ready_i,
  input wire       mst_rsp_valid_i,
  input wire [7:0] mst_rsp_func_i,
  input wire [7:0] mst_rsp_exc_i,
  input wire [7:0] last_response_function_query_o,
  input wire [7:0] last_exception_code_query_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_answer_delay: assert property (req_valid_i && req_ready_o && req_last_i |-> ##2 rsp_valid_o)
    else $error("response not raised two cycles after last byte");
  a_busy_refuse: assert property (rsp_valid_o |-> !req_ready_o)
    else $error("request taken while answering");
  a_byte_hold: assert property (rsp_valid_o && !rsp_ready_i |=> rsp_valid_o && $stable(rsp_byte_o))
    else $error("response byte moved while stalled");
  a_end_release: assert property (rsp_valid_o && rsp_ready_i && rsp_last_o |=> !rsp_valid_o)
    else $error("valid kept after last byte");
  a_normal_func: assert property ($rose(rsp_valid_o) && !rsp_byte_o[7] |->
    rsp_byte_o == 8'h02 || rsp_byte_o == 8'h03)
    else $error("normal reply for unsupported function");
  a_exc_len: assert property ($rose(rsp_valid_o) && rsp_byte_o[7] |-> !rsp_last_o)
    else $error("exception reply lacks code byte");
  a_func_store: assert property (mst_rsp_valid_i |=>
    last_response_function_query_o == $past(mst_rsp_func_i))
    else $error("last function not recorded");
  a_exc_store: assert property (mst_rsp_valid_i && mst_rsp_func_i[7] |=>
    last_exception_code_query_o == $past(mst_rsp_exc_i))
    else $error("exception code not kept");
  a_exc_keep: assert property (mst_rsp_valid_i && !mst_rsp_func_i[7] |=>
    $stable(last_exception_code_query_o))
    else $error("exception code overwritten");
endmodule
bind mbrd_slave mbrd_slave_asserts i_chk (.clk_i(clk_i), .rstn_i(rstn_i),
  .req_valid_i(req_valid_i), .req_last_i(req_last_i), .req_ready_o(req_ready_o),
  .rsp_valid_o(rsp_valid_o), .rsp_byte_o(rsp_byte_o), .rsp_last_o(rsp_last_o),
  .rsp_ready_i(rsp_ready_i), .mst_rsp_valid_i(mst_rsp_valid_i),
  .mst_rsp_func_i(mst_rsp_func_i), .mst_rsp_exc_i(mst_rsp_exc_i),
  .last_response_function_query_o(last_response_function_query_o),
  .last_exception_code_query_o(last_exception_code_query_o));

/* File: tb/mbrd_master_model.sv */
// remote master: sends request frames, collects response bytes
// assumes calls start just after a rising edge
module mbrd_master_model (
  input  wire       clk_i,
  output reg        req_valid_o,
  output reg  [7:0] req_byte_o,
  output reg        req_last_o,
  input  wire       req_ready_i,
  input  wire       rsp_valid_i,
  input  wire [7:0] rsp_byte_i,
  input  wire       rsp_last_i,
  output reg        rsp_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  integer     seed = 91781;
  logic [7:0] got[$];
  initial begin
    req_valid_o = 1'b0;
    req_byte_o = 8'hA5;
    req_last_o = 1'b0;
    rsp_ready_o = 1'b0;
  end
  task put(input [7:0] b, input l);
    req_valid_o <= 1'b1;
    req_byte_o <= b;
    req_last_o <= l;
    @(posedge clk_i);
    while (req_ready_i !== 1'b1) @(posedge clk_i);
  endtask
  task xfer(input [7:0] f, input [15:0] a, input [15:0] q);
    got.delete();
    put(f, 0); put(a[15:8], 0); put(a[7:0], 0); put(q[15:8], 0); put(q[7:0], 1);
    req_valid_o <= 1'b0;
    req_byte_o <= ~q[7:0];
    // random stalls on the response side
    do begin
      rsp_ready_o <= 1'($random(seed));
      @(posedge clk_i);
      if (rsp_valid_i === 1'b1 && rsp_ready_o === 1'b1) got.push_back(rsp_byte_i);
    end while (!(rsp_valid_i === 1'b1 && rsp_ready_o === 1'b1 && rsp_last_i === 1'b1));
    rsp_ready_o <= 1'b0;
  endtask
endmodule

/* File: tb/test_modbus_slave_read_inputs_regs.sv */
// random read requests checked against a bench model
// assumes the master model owns both byte handshakes
module test_modbus_slave_read_inputs_regs;
  timeunit 1ns;
  timeprecision 1ps;
  reg         clk_i = 0;
  reg         rstn_i = 0;
  reg  [15:0] din = 0;
  reg  [255:0] ain = 0;
  reg  [255:0] aout = 0;
  reg         fmt = 0;
  reg         swp = 0;
  reg         m_vld = 0;
  reg  [7:0]  m_fn = 0;
  reg  [7:0]  m_ex = 0;
  reg  [7:0]  ex_want = 0;
  reg  [7:0]  f;
  wire        rv, rl, rr, sv, sl, sr;
  wire [7:0]  rb, sb, lf, le;
  integer     seed = 91781, bad_count = 0, cmp_count = 0, n, k, a, q;
  logic [7:0] e[$];
  mbrd_slave i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .digital_in_active_i(din),
    .analog_in_words_i(ain), .analog_out_words_i(aout), .analog_value_format_select_i(fmt),
    .holding_input_swap_select_i(swp), .req_valid_i(rv), .req_byte_i(rb), .req_last_i(rl),
    .req_ready_o(rr), .rsp_valid_o(sv), .rsp_byte_o(sb), .rsp_last_o(sl), .rsp_ready_i(sr),
    .mst_rsp_valid_i(m_vld), .mst_rsp_func_i(m_fn), .mst_rsp_exc_i(m_ex),
    .last_response_function_query_o(lf), .last_exception_code_query_o(le));
  mbrd_master_model i_mst (.clk_i(clk_i), .req_valid_o(rv), .req_byte_o(rb), .req_last_o(rl),
    .req_ready_i(rr), .rsp_valid_i(sv), .rsp_byte_i(sb), .rsp_last_i(sl), .rsp_ready_o(sr));
  task chk(input [7:0] g, input [7:0] x);
    cmp_count++;
    if (g !== x) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, g, x);
    end
  endtask
  task expect_rsp;
    reg [255:0] w;
    integer j;
    w = swp ? aout : ain;
    if (f != 8'h02 && f != 8'h03) e = '{f | 8'h80, 8'h01};
    else if (q < 1 || a + q > 16 || (f == 8'h03 && !fmt && (q > 8 || a[0] || q[0])))
      e = '{f | 8'h80, 8'h02};
    else begin
      e = '{f, 8'(f == 8'h02 ? (q + 7) / 8 : 2 * q)};
      for (j = 0; j < q; j++) begin
        if (f == 8'h03) begin
          e.push_back(w[16 * (a + j) + 8 +: 8]);
          e.push_back(w[16 * (a + j) +: 8]);
        end else begin
          if (j % 8 == 0) e.push_back(8'h00);
          e[e.size() - 1][j % 8] = ~din[a + j];
        end
      end
    end
  endtask
  task tally_and_finish;
    if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial forever #2 clk_i = ~clk_i;
  initial begin
    #300000 bad_count++;
    tally_and_finish;
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    for (n = 0; n < 300; n++) begin
      din <= $random(seed);
      for (k = 0; k < 8; k++) ain[32 * k +: 32] <= $random(seed);
      for (k = 0; k < 8; k++) aout[32 * k +: 32] <= $random(seed);
      fmt <= $random(seed);
      swp <= $random(seed);
      m_vld <= 1'b1;
      m_fn <= 8'h02 + n[0] + (n[1] ? 8'h80 : 8'h00);
      m_ex <= $random(seed);
      @(posedge clk_i);
      m_vld <= 1'b0;
      if (m_fn[7]) ex_want = m_ex;
      @(posedge clk_i);
      chk(lf, m_fn);
      chk(le, ex_want);
      f = 8'({$random(seed)} % 4 + 1);
      a = {$random(seed)} % 18;
      q = {$random(seed)} % 19;
      if (n == 0) begin
        f = 8'h02;
        a = 2;
        q = 12;
      end
      if (n == 1 || n == 2) begin
        f = 8'h03;
        a = n == 1 ? 0 : 14;
        q = n == 1 ? 16 : 4;
        fmt <= n == 1;
      end
      i_mst.xfer(f, a[15:0], q[15:0]);
      expect_rsp;
      chk(8'(i_mst.got.size()), 8'(e.size()));
      for (k = 0; k < e.size(); k++)
        chk(i_mst.got[k], e[k]);
    end
    tally_and_finish;
  end
endmodule
